// >>> hdl/link_status_pkg.sv
// Constants and carrier types for the link status flag block
package link_status_pkg;
  localparam int NUM_SETS = 12;
  localparam int NUM_BLOCKS = 128;
  localparam int WORD_W = 16;
  localparam int ARRAY_WORDS = 8;
  localparam int SET_W = 4;
  localparam int IDX_W = 10;
  localparam int WORD_SEL_W = 6;
  // Flag region layout, in 16-bit words
  localparam logic [IDX_W-1:0] WORDS_PER_SET = 10'h032;
  localparam logic [WORD_SEL_W-1:0] FLAG_WORD = 6'h00;
  localparam logic [WORD_SEL_W-1:0] STATE_WORD = 6'h02;
  localparam logic [WORD_SEL_W-1:0] MOD_WORD = 6'h0a;
  localparam logic [WORD_SEL_W-1:0] TRX_WORD = 6'h12;
  localparam logic [WORD_SEL_W-1:0] ERR_WORD = 6'h1a;
  localparam logic [WORD_SEL_W-1:0] CFG_WORD = 6'h22;
  localparam int FLAG_ALL_NORMAL_BIT = 0;
  localparam int FLAG_TROUBLE_BIT = 1;
  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] AREA_END_IDX = 10'h258;
  localparam logic [IDX_W-1:0] CTRL_IDX = 10'h258;
  localparam logic [IDX_W-1:0] IRQ_STAT_IDX = 10'h259;
  localparam logic [IDX_W-1:0] IRQ_MASK_IDX = 10'h25a;
  localparam int IRQ_W = 24;
  localparam int IRQ_NORMAL_LSB = 12;
  localparam logic [NUM_SETS-1:0] CTRL_RST = 12'hfff;
  localparam logic [IRQ_W-1:0] IRQ_RST = 24'h000000;

  typedef struct packed {
    logic running;
    logic xfer_ok;
    logic error;
  } block_status_t;

  typedef struct packed {
    logic trouble;
    logic all_normal;
  } set_flags_t;
endpackage

// >>> hdl/set_flags.sv
// Per parameter set block arrays and link flags
`timescale 1ns/10ps
module set_flags (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Station status of this set
  input wire link_status_pkg::block_status_t [link_status_pkg::NUM_BLOCKS-1:0] status_i,
  input wire logic [link_status_pkg::NUM_BLOCKS-1:0] configured_i,
  input wire logic param_ok_i,
  input wire logic link_en_i,
  // Block arrays and flags
  output logic [link_status_pkg::NUM_BLOCKS-1:0] running_o,
  output logic [link_status_pkg::NUM_BLOCKS-1:0] xfer_ok_o,
  output logic [link_status_pkg::NUM_BLOCKS-1:0] error_o,
  output logic [link_status_pkg::NUM_BLOCKS-1:0] configured_o,
  output logic [link_status_pkg::NUM_BLOCKS-1:0] overall_o,
  output link_status_pkg::set_flags_t flags_o
);
  logic [link_status_pkg::NUM_BLOCKS-1:0] run_w;
  logic [link_status_pkg::NUM_BLOCKS-1:0] trx_w;
  logic [link_status_pkg::NUM_BLOCKS-1:0] err_w;
  logic [link_status_pkg::NUM_BLOCKS-1:0] run_q;
  logic [link_status_pkg::NUM_BLOCKS-1:0] trx_q;
  logic [link_status_pkg::NUM_BLOCKS-1:0] err_q;
  logic [link_status_pkg::NUM_BLOCKS-1:0] cfg_q;
  logic param_ok_q;
  logic normal_q;
  logic trouble_q;
  wire [link_status_pkg::NUM_BLOCKS-1:0] ok_w;
  wire all_ok_w;
  wire any_bad_w;

  // Unconfigured blocks show zero in every array
  always_comb begin
    for (int k = 0; k < link_status_pkg::NUM_BLOCKS; k++) begin
      run_w[k] = status_i[k].running & configured_i[k];
      trx_w[k] = status_i[k].xfer_ok & configured_i[k];
      err_w[k] = status_i[k].error & configured_i[k];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_q <= '0;
      trx_q <= '0;
      err_q <= '0;
      cfg_q <= '0;
      param_ok_q <= 1'b0;
    end else begin
      run_q <= run_w;
      trx_q <= trx_w;
      err_q <= err_w;
      cfg_q <= configured_i;
      param_ok_q <= param_ok_i;
    end
  end

  assign ok_w = run_q & trx_q & ~err_q;
  assign all_ok_w = (|cfg_q) && (&(~cfg_q | ok_w)) && param_ok_q;
  assign any_bad_w = |(cfg_q & (~run_q | err_q | ~trx_q));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      normal_q <= 1'b0;
    end else if (!link_en_i) begin
      normal_q <= 1'b0;
    end else if (all_ok_w) begin
      normal_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trouble_q <= 1'b0;
    end else begin
      trouble_q <= normal_q & link_en_i & any_bad_w;
    end
  end

  assign running_o = run_q;
  assign xfer_ok_o = trx_q;
  assign error_o = err_q;
  assign configured_o = cfg_q;
  assign overall_o = ok_w;
  assign flags_o.all_normal = normal_q;
  assign flags_o.trouble = trouble_q;
endmodule

// >>> hdl/flag_word_sel.sv
// Selects one 16-bit word of a set's flag region
`timescale 1ns/10ps
module flag_word_sel (
  // Set contents
  input wire logic [link_status_pkg::NUM_BLOCKS-1:0] running_i,
  input wire logic [link_status_pkg::NUM_BLOCKS-1:0] xfer_ok_i,
  input wire logic [link_status_pkg::NUM_BLOCKS-1:0] error_i,
  input wire logic [link_status_pkg::NUM_BLOCKS-1:0] configured_i,
  input wire logic [link_status_pkg::NUM_BLOCKS-1:0] overall_i,
  input wire link_status_pkg::set_flags_t flags_i,
  // Word select
  input wire logic [link_status_pkg::WORD_SEL_W-1:0] word_i,
  output logic [link_status_pkg::WORD_W-1:0] word_o
);
  logic [link_status_pkg::WORD_W-1:0] flag_word;
  logic [link_status_pkg::WORD_SEL_W-1:0] rel;

  // Blocks 16j..16j+15 sit in word j of each array, block 16j at bit 0
  function automatic logic [15:0] pick(input logic [127:0] arr, input logic [5:0] w);
    logic [2:0] j;
    j = w[2:0];
    pick = arr[16*j +: 16];
  endfunction

  always_comb begin
    flag_word = '0;
    flag_word[link_status_pkg::FLAG_ALL_NORMAL_BIT] = flags_i.all_normal;
    flag_word[link_status_pkg::FLAG_TROUBLE_BIT] = flags_i.trouble;
    word_o = '0;
    rel = '0;
    if (word_i == link_status_pkg::FLAG_WORD) begin
      word_o = flag_word;
    end else if (word_i >= link_status_pkg::STATE_WORD && word_i < link_status_pkg::MOD_WORD) begin
      rel = word_i - link_status_pkg::STATE_WORD;
      word_o = pick(overall_i, rel);
    end else if (word_i >= link_status_pkg::MOD_WORD && word_i < link_status_pkg::TRX_WORD) begin
      rel = word_i - link_status_pkg::MOD_WORD;
      word_o = pick(running_i, rel);
    end else if (word_i >= link_status_pkg::TRX_WORD && word_i < link_status_pkg::ERR_WORD) begin
      rel = word_i - link_status_pkg::TRX_WORD;
      word_o = pick(xfer_ok_i, rel);
    end else if (word_i >= link_status_pkg::ERR_WORD && word_i < link_status_pkg::CFG_WORD) begin
      rel = word_i - link_status_pkg::ERR_WORD;
      word_o = pick(error_i, rel);
    end else if (word_i >= link_status_pkg::CFG_WORD && word_i < link_status_pkg::CFG_WORD + 6'h08) begin
      rel = word_i - link_status_pkg::CFG_WORD;
      word_o = pick(configured_i, rel);
    end
  end
endmodule

// >>> hdl/link_status_flags.sv
// Link status flags for twelve parameter sets with a Wishbone register view
`timescale 1ns/10ps
module link_status_flags (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Station status per set and block
  input wire link_status_pkg::block_status_t [link_status_pkg::NUM_SETS-1:0][link_status_pkg::NUM_BLOCKS-1:0]
    status_i,
  input wire logic [link_status_pkg::NUM_SETS-1:0][link_status_pkg::NUM_BLOCKS-1:0] configured_i,
  input wire logic [link_status_pkg::NUM_SETS-1:0] param_ok_i,
  // Flags and interrupt
  output link_status_pkg::set_flags_t [link_status_pkg::NUM_SETS-1:0] flags_o,
  output logic irq_o
);
  logic [link_status_pkg::NUM_BLOCKS-1:0] run_a [link_status_pkg::NUM_SETS];
  logic [link_status_pkg::NUM_BLOCKS-1:0] trx_a [link_status_pkg::NUM_SETS];
  logic [link_status_pkg::NUM_BLOCKS-1:0] err_a [link_status_pkg::NUM_SETS];
  logic [link_status_pkg::NUM_BLOCKS-1:0] cfg_a [link_status_pkg::NUM_SETS];
  logic [link_status_pkg::NUM_BLOCKS-1:0] ovr_a [link_status_pkg::NUM_SETS];
  link_status_pkg::set_flags_t [link_status_pkg::NUM_SETS-1:0] flags_w;
  link_status_pkg::set_flags_t [link_status_pkg::NUM_SETS-1:0] flags_prev_q;
  logic [link_status_pkg::NUM_SETS-1:0] ctrl_q;
  logic [link_status_pkg::IRQ_W-1:0] stat_q;
  logic [link_status_pkg::IRQ_W-1:0] stat_d;
  logic [link_status_pkg::IRQ_W-1:0] mask_q;
  logic [link_status_pkg::IRQ_W-1:0] events_w;
  logic [31:0] dat_q;
  logic ack_q;
  logic [link_status_pkg::WORD_W-1:0] area_word;

  // Per set flag logic
  genvar s;
  generate
    for (s = 0; s < link_status_pkg::NUM_SETS; s++) begin : g_set
      set_flags u_set (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .status_i(status_i[s]),
        .configured_i(configured_i[s]),
        .param_ok_i(param_ok_i[s]),
        .link_en_i(ctrl_q[s]),
        .running_o(run_a[s]),
        .xfer_ok_o(trx_a[s]),
        .error_o(err_a[s]),
        .configured_o(cfg_a[s]),
        .overall_o(ovr_a[s]),
        .flags_o(flags_w[s])
      );
      assign events_w[s] = flags_w[s].trouble & ~flags_prev_q[s].trouble;
      assign events_w[link_status_pkg::IRQ_NORMAL_LSB + s] = flags_w[s].all_normal & ~flags_prev_q[s].all_normal;
    end
  endgenerate

  assign flags_o = flags_w;

  // Address decode
  wire [link_status_pkg::IDX_W-1:0] idx_w = adr_i[link_status_pkg::IDX_W+1:2];
  wire hi_zero_w = ~|adr_i[31:link_status_pkg::IDX_W+2];
  wire in_area_w = hi_zero_w && (idx_w < link_status_pkg::AREA_END_IDX);
  wire [link_status_pkg::IDX_W-1:0] set_full_w = idx_w / link_status_pkg::WORDS_PER_SET;
  wire [link_status_pkg::SET_W-1:0] set_w = in_area_w ? set_full_w[link_status_pkg::SET_W-1:0] : '0;
  wire [link_status_pkg::IDX_W-1:0] base_w = 10'(set_full_w * link_status_pkg::WORDS_PER_SET);
  wire [link_status_pkg::IDX_W-1:0] word_full_w = idx_w - base_w;
  wire [link_status_pkg::WORD_SEL_W-1:0] word_w = word_full_w[link_status_pkg::WORD_SEL_W-1:0];
  wire ctrl_hit_w = hi_zero_w && (idx_w == link_status_pkg::CTRL_IDX);
  wire stat_hit_w = hi_zero_w && (idx_w == link_status_pkg::IRQ_STAT_IDX);
  wire mask_hit_w = hi_zero_w && (idx_w == link_status_pkg::IRQ_MASK_IDX);
  wire req_w = cyc_i & stb_i & ~ack_q;
  wire wr_w = req_w & we_i;
  wire [31:0] bmask_w = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  wire [31:0] wbits_w = dat_i & bmask_w;

  flag_word_sel u_word (
    .running_i(run_a[set_w]),
    .xfer_ok_i(trx_a[set_w]),
    .error_i(err_a[set_w]),
    .configured_i(cfg_a[set_w]),
    .overall_i(ovr_a[set_w]),
    .flags_i(flags_w[set_w]),
    .word_i(word_w),
    .word_o(area_word)
  );

  wire [31:0] rd_w = in_area_w ? {16'h0000, area_word} :
                     ctrl_hit_w ? {20'h00000, ctrl_q} :
                     stat_hit_w ? {8'h00, stat_q} :
                     mask_hit_w ? {8'h00, mask_q} : 32'h00000000;

  // Sticky status: a new event wins over a write-one clear
  assign stat_d = (stat_q & ~((stat_hit_w & wr_w) ? wbits_w[link_status_pkg::IRQ_W-1:0] : '0)) | events_w;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end else begin
      ack_q <= req_w;
      dat_q <= req_w ? rd_w : dat_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= link_status_pkg::CTRL_RST;
      mask_q <= link_status_pkg::IRQ_RST;
    end else if (wr_w && ctrl_hit_w) begin
      ctrl_q <= (ctrl_q & ~bmask_w[link_status_pkg::NUM_SETS-1:0]) | wbits_w[link_status_pkg::NUM_SETS-1:0];
    end else if (wr_w && mask_hit_w) begin
      mask_q <= (mask_q & ~bmask_w[link_status_pkg::IRQ_W-1:0]) | wbits_w[link_status_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_q <= link_status_pkg::IRQ_RST;
      flags_prev_q <= '0;
    end else begin
      stat_q <= stat_d;
      flags_prev_q <= flags_w;
    end
  end

  assign irq_o = |(stat_q & mask_q);
  assign ack_o = ack_q;
  assign dat_o = dat_q;
endmodule

// >>> testbench/link_status_flags_assertions.sv
// Port checker for the link status flag block
`timescale 1ns/10ps
module link_status_flags_assertions (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus and status
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic ack_o,
  input wire link_status_pkg::block_status_t [link_status_pkg::NUM_SETS-1:0][link_status_pkg::NUM_BLOCKS-1:0]
    status_i,
  input wire logic [link_status_pkg::NUM_SETS-1:0][link_status_pkg::NUM_BLOCKS-1:0] configured_i,
  input wire logic [link_status_pkg::NUM_SETS-1:0] param_ok_i,
  // Flags
  input wire link_status_pkg::set_flags_t [link_status_pkg::NUM_SETS-1:0] flags_o
);
  logic good0, an, tr, ctrl_wr;
  assign an = flags_o[0].all_normal;
  assign tr = flags_o[0].trouble;
  assign ctrl_wr = cyc_i && stb_i && we_i && adr_i[11:2] == link_status_pkg::CTRL_IDX;
  // Set 0 has every configured block running, healthy and error-free
  always_comb begin
    good0 = 1'b1;
    for (int b = 0; b < link_status_pkg::NUM_BLOCKS; b++) begin
      if (configured_i[0][b] && status_i[0][b] != 3'b110) good0 = 1'b0;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("request not acked");
  ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack held too long");
  ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
  normal_hold_a: assert property (an && !ctrl_wr |=> an) else $error("all-normal dropped");
  normal_cause_a: assert property ($rose(an) |-> $past(good0 && param_ok_i[0], 2))
    else $error("all-normal without cause");
  trouble_gate_a: assert property (tr |-> $past(an)) else $error("trouble without all-normal");
  trouble_rise_a: assert property (an && !good0 |-> ##[1:3] (tr || !an)) else $error("trouble missed");
  trouble_clear_a: assert property (good0 [*4] |=> !tr) else $error("trouble stuck");
endmodule
bind link_status_flags link_status_flags_assertions i_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
  .ack_o, .status_i, .configured_i, .param_ok_i, .flags_o);

// >>> testbench/station_model.sv
// Remote stations: one configured block per set, faults injected on set 0
`timescale 1ns/10ps
module station_model (
  // Fault select for set 0 block 5
  input wire logic [1:0] fault_i,
  // Station status
  output link_status_pkg::block_status_t [link_status_pkg::NUM_SETS-1:0][link_status_pkg::NUM_BLOCKS-1:0]
    status_o,
  output logic [link_status_pkg::NUM_SETS-1:0][link_status_pkg::NUM_BLOCKS-1:0] configured_o,
  output logic [link_status_pkg::NUM_SETS-1:0] param_ok_o
);
  always_comb begin
    for (int s = 0; s < link_status_pkg::NUM_SETS; s++) begin
      for (int b = 0; b < link_status_pkg::NUM_BLOCKS; b++) begin
        configured_o[s][b] = (b == s * 10 + 5);
        // Unconfigured blocks show stopped with error, so masking is visible
        status_o[s][b] = configured_o[s][b] ? 3'b110 : 3'b001;
      end
      param_ok_o[s] = 1'b1;
    end
    status_o[0][5] = 3'b110 ^ {fault_i == 2'h1, fault_i == 2'h3, fault_i == 2'h2};
  end
endmodule

// >>> testbench/testbench.sv
// Self-checking bench for the link status flag block
`timescale 1ns/10ps
module testbench;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o;
  logic [31:0] adr_i, dat_i, dat_o, rd;
  logic [3:0] sel_i;
  logic [1:0] fault;
  link_status_pkg::block_status_t [link_status_pkg::NUM_SETS-1:0][link_status_pkg::NUM_BLOCKS-1:0] status;
  logic [link_status_pkg::NUM_SETS-1:0][link_status_pkg::NUM_BLOCKS-1:0] configured;
  logic [link_status_pkg::NUM_SETS-1:0] param_ok;
  link_status_pkg::set_flags_t [link_status_pkg::NUM_SETS-1:0] flags;
  int bad_count, num_checks, cycles;
  station_model i_model (.fault_i(fault), .status_o(status), .configured_o(configured), .param_ok_o(param_ok));
  link_status_flags i_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .status_i(status), .configured_i(configured), .param_ok_i(param_ok), .flags_o(flags), .irq_o);
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [9:0] idx, input logic [31:0] wd);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= we;
    sel_i <= 4'hf;
    adr_i <= {20'h00000, idx, 2'h0};
    dat_i <= wd;
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic t_arrays();
    logic [5:0] wsel[5];
    logic [9:0] base;
    int b;
    wsel = '{link_status_pkg::STATE_WORD, link_status_pkg::MOD_WORD, link_status_pkg::TRX_WORD,
      link_status_pkg::ERR_WORD, link_status_pkg::CFG_WORD};
    for (int s = 0; s < link_status_pkg::NUM_SETS; s++) begin
      b = s * 10 + 5;
      base = 10'(s) * link_status_pkg::WORDS_PER_SET;
      check(32'(flags[s]), 32'h1);
      wb(1'b0, base, 32'h0);
      check(rd, 32'h1);
      foreach (wsel[i]) begin
        wb(1'b0, base + 10'(wsel[i]) + 10'(b / 16), 32'h0);
        check(rd, (wsel[i] == link_status_pkg::ERR_WORD) ? 32'h0 : 32'h1 << (b % 16));
      end
    end
  endtask
  task automatic t_faults();
    for (int f = 1; f < 4; f++) begin
      fault <= 2'(f);
      repeat (4) @(posedge clk_i);
      check(32'(flags[0]), 32'h3);
      check(32'(flags[1]), 32'h1);
      wb(1'b0, 10'(link_status_pkg::STATE_WORD), 32'h0);
      check(rd, 32'h0);
      wb(1'b0, 10'(link_status_pkg::ERR_WORD), 32'h0);
      check(rd, (f == 2) ? 32'h20 : 32'h0);
      fault <= 2'h0;
      repeat (4) @(posedge clk_i);
      check(32'(flags[0]), 32'h1);
    end
  endtask
  task automatic t_irq();
    check(32'(irq_o), 32'h0);
    wb(1'b1, link_status_pkg::IRQ_MASK_IDX, 32'h1);
    check(32'(irq_o), 32'h1);
    wb(1'b1, link_status_pkg::IRQ_STAT_IDX, 32'h1);
    check(32'(irq_o), 32'h0);
    wb(1'b0, link_status_pkg::IRQ_STAT_IDX, 32'h0);
    check(rd, 32'h00fff000);
    wb(1'b0, 10'h3ff, 32'h0);
    check(rd, 32'h0);
    wb(1'b1, 10'h000, 32'h0);
    check(32'(flags[0]), 32'h1);
  endtask
  task automatic t_disable();
    wb(1'b1, link_status_pkg::CTRL_IDX, 32'hffe);
    fault <= 2'h1;
    repeat (4) @(posedge clk_i);
    check(32'(flags[0]), 32'h0);
    check(32'(flags[1]), 32'h1);
    fault <= 2'h0;
    repeat (3) @(posedge clk_i);
    wb(1'b1, link_status_pkg::CTRL_IDX, 32'hfff);
    repeat (3) @(posedge clk_i);
    check(32'(flags[0]), 32'h1);
  endtask
  // Mid-run reset: arrays read zero in the first cycle after release, then refill
  task automatic t_reset();
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    check(32'(flags), 32'h0);
    check(32'(irq_o), 32'h0);
    rst_i <= 1'b0;
    wb(1'b0, 10'(link_status_pkg::MOD_WORD), 32'h0);
    check(rd, 32'h0);
    wb(1'b0, 10'(link_status_pkg::MOD_WORD), 32'h0);
    check(rd, 32'h20);
    repeat (2) @(posedge clk_i);
    check(32'(flags[0]), 32'h1);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    {bad_count, num_checks, cycles} = '0;
    {cyc_i, stb_i, we_i, sel_i, adr_i, dat_i, fault} = '0;
    rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    check(32'(flags), 32'h0);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    t_arrays();
    t_faults();
    t_irq();
    t_disable();
    t_reset();
    give_verdict();
  end
endmodule
